/* ebt_map.svh */
// offsets, field positions and reset values of the eight-bit compare timer
`ifndef EBT_MAP_SVH
`define EBT_MAP_SVH

// register indices; byte address is four times the index
`define EBT_IDX_COUNT   10'h0ea
`define EBT_IDX_CTRL    10'h0eb
`define EBT_IDX_CCTL    10'h0ec
`define EBT_IDX_CVAL    10'h0ed

// timer_control_reg fields
`define EBT_CTL_DIV     7:5
`define EBT_CTL_START   4
`define EBT_CTL_OVERFLOW_IRQ_MASK   3
`define EBT_CTL_CLR     2
`define EBT_CTL_MODE    1:0

// chan0_control_reg fields
`define EBT_CC_IM       6
`define EBT_CC_ACT      5:3
`define EBT_CC_EN       2
`define EBT_CC_RSV      1:0

// reset values
`define EBT_RST_DIV     3'h0
`define EBT_RST_MODE    2'h0
`define EBT_RST_ACT     3'h0
`define EBT_RST_RSV     2'h0
`define EBT_RST_BYTE    8'h00
`define EBT_RST_PRESC   7'h00

// count limits
`define EBT_CNT_MAX     8'hff
`define EBT_CNT_ZERO    8'h00
`define EBT_CNT_ONE     8'h01
`define EBT_RDATA_ZERO  32'h0000_0000

`endif

/* ebt_pkg.sv */
// types of the eight-bit compare timer
package ebt_pkg;

    typedef enum logic [1:0] {
        EBT_FREE   = 2'h0,
        EBT_DOWN   = 2'h1,
        EBT_MODULO = 2'h2,
        EBT_UPDOWN = 2'h3
    } ebt_mode_type;

    typedef enum logic [2:0] {
        EBT_SET       = 3'h0,
        EBT_CLEAR     = 3'h1,
        EBT_TOGGLE    = 3'h2,
        EBT_SET_UP    = 3'h3,
        EBT_CLR_UP    = 3'h4,
        EBT_SET_CLRFF = 3'h5,
        EBT_CLR_SET0  = 3'h6,
        EBT_UNUSED    = 3'h7
    } ebt_action_type;

    typedef struct packed {
        logic [2:0]   div;
        logic         start;
        logic         overflow_irq_mask;
        ebt_mode_type mode;
    } ebt_ctrl_type;

    typedef struct packed {
        logic           channel_irq_mask;
        ebt_action_type compare_output_action;
        logic           compare_en;
        logic [1:0]     rsv;
    } ebt_cctl_type;

endpackage

/* ebt_timer.sv */
// eight-bit timer with prescaler, four count modes and one compare channel
`timescale 1ns/1ps
`default_nettype none
`include "ebt_map.svh"

module ebt_timer #(
    parameter int PRESC_W = 7
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // prescaler input tick, same clock domain
    input  wire logic        tick,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // compare output and interrupt requests
    output logic             chan0_out,
    output logic             chan0_irq,
    output logic             overflow_irq
);

    ebt_pkg::ebt_ctrl_type ctrl_q;
    ebt_pkg::ebt_cctl_type cctl_q;
    logic [7:0]         cval_q;
    logic [7:0]         cnt_q;
    logic [7:0]         cnt_d;
    logic               dir_up_q;
    logic               dir_up_d;
    logic               start_prev_q;
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_mask;
    logic               upd;
    logic               ovf_ev;
    logic               step_up;
    logic               match_ev;
    logic               zero_ev;
    logic               max_ev;
    logic               act_en;
    logic               setup;
    logic               wr;
    logic               hit;
    logic [9:0]         idx;
    logic               clr_wr;
    logic [31:0]        rdata_d;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic               out_q;
    logic               out_d;
    logic               cirq_q;
    logic               oirq_q;

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign chan0_out    = out_q;
    assign chan0_irq    = cirq_q;
    assign overflow_irq = oirq_q;

    // apb decode; one access cycle, no wait
    assign idx    = paddr[11:2];
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite & pready_q & ~pslverr_q;
    assign hit    = (idx == `EBT_IDX_COUNT) | (idx == `EBT_IDX_CTRL)
                  | (idx == `EBT_IDX_CCTL) | (idx == `EBT_IDX_CVAL);
    assign clr_wr = wr & (idx == `EBT_IDX_CTRL) & pwdata[`EBT_CTL_CLR];

    always_comb begin
        rdata_d = `EBT_RDATA_ZERO;
        case (idx)
            `EBT_IDX_COUNT: rdata_d[7:0] = cnt_q;
            `EBT_IDX_CTRL: begin
                rdata_d[`EBT_CTL_DIV]   = ctrl_q.div;
                rdata_d[`EBT_CTL_START] = ctrl_q.start;
                rdata_d[`EBT_CTL_OVERFLOW_IRQ_MASK] = ctrl_q.overflow_irq_mask;
                rdata_d[`EBT_CTL_CLR]   = 1'b0;
                rdata_d[`EBT_CTL_MODE]  = ctrl_q.mode;
            end
            `EBT_IDX_CCTL: begin
                rdata_d[`EBT_CC_IM]  = cctl_q.channel_irq_mask;
                rdata_d[`EBT_CC_ACT] = cctl_q.compare_output_action;
                rdata_d[`EBT_CC_EN]  = cctl_q.compare_en;
                rdata_d[`EBT_CC_RSV] = cctl_q.rsv;
            end
            `EBT_IDX_CVAL: rdata_d[7:0] = cval_q;
            default: rdata_d = `EBT_RDATA_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `EBT_RDATA_ZERO;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup) begin
                prdata_q <= rdata_d;
            end
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_q.div               <= `EBT_RST_DIV;
            ctrl_q.start             <= 1'b0;
            ctrl_q.overflow_irq_mask <= 1'b1;
            ctrl_q.mode              <= ebt_pkg::EBT_FREE;
        end else if (wr && idx == `EBT_IDX_CTRL) begin
            ctrl_q.div               <= pwdata[`EBT_CTL_DIV];
            ctrl_q.start             <= pwdata[`EBT_CTL_START];
            ctrl_q.overflow_irq_mask <= pwdata[`EBT_CTL_OVERFLOW_IRQ_MASK];
            ctrl_q.mode <= ebt_pkg::ebt_mode_type'(pwdata[`EBT_CTL_MODE]);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cctl_q.channel_irq_mask      <= 1'b1;
            cctl_q.compare_output_action <= ebt_pkg::EBT_SET;
            cctl_q.compare_en            <= 1'b0;
            cctl_q.rsv                   <= `EBT_RST_RSV;
        end else if (wr && idx == `EBT_IDX_CCTL) begin
            cctl_q.channel_irq_mask      <= pwdata[`EBT_CC_IM];
            cctl_q.compare_output_action <=
                ebt_pkg::ebt_action_type'(pwdata[`EBT_CC_ACT]);
            cctl_q.compare_en            <= pwdata[`EBT_CC_EN];
            cctl_q.rsv                   <= pwdata[`EBT_CC_RSV];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cval_q <= `EBT_RST_BYTE;
        end else if (wr && idx == `EBT_IDX_CVAL) begin
            cval_q <= pwdata[7:0];
        end
    end

    // prescaler; mask follows div at once
    assign presc_mask = PRESC_W'(({{PRESC_W{1'b0}}, 1'b1} << ctrl_q.div) - 1'b1);
    assign upd        = tick & ctrl_q.start & ((presc_q & presc_mask) == presc_mask);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            presc_q <= `EBT_RST_PRESC;
        end else if (tick) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // next count per mode
    always_comb begin
        cnt_d    = cnt_q;
        dir_up_d = dir_up_q;
        ovf_ev   = 1'b0;
        step_up  = 1'b1;
        case (ctrl_q.mode)
            ebt_pkg::EBT_FREE: begin
                cnt_d  = cnt_q + `EBT_CNT_ONE;
                ovf_ev = (cnt_q == `EBT_CNT_MAX);
            end
            ebt_pkg::EBT_DOWN: begin
                step_up = 1'b0;
                if (cnt_q != `EBT_CNT_ZERO) begin
                    cnt_d  = cnt_q - `EBT_CNT_ONE;
                    ovf_ev = (cnt_q == `EBT_CNT_ONE);
                end
            end
            ebt_pkg::EBT_MODULO: begin
                if (cnt_q == cval_q) begin
                    cnt_d  = `EBT_CNT_ZERO;
                    ovf_ev = 1'b1;
                end else begin
                    cnt_d = cnt_q + `EBT_CNT_ONE;
                end
            end
            ebt_pkg::EBT_UPDOWN: begin
                if (dir_up_q && cnt_q < cval_q) begin
                    cnt_d = cnt_q + `EBT_CNT_ONE;
                end else if (cnt_q != `EBT_CNT_ZERO) begin
                    step_up  = 1'b0;
                    dir_up_d = 1'b0;
                    cnt_d    = cnt_q - `EBT_CNT_ONE;
                    ovf_ev   = (cnt_q == `EBT_CNT_ONE);
                end else begin
                    dir_up_d = 1'b1;
                    if (cval_q != `EBT_CNT_ZERO) begin
                        cnt_d = `EBT_CNT_ONE;
                    end
                end
            end
            default: cnt_d = cnt_q;
        endcase
    end

    // counter; clear beats counting
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q        <= `EBT_CNT_ZERO;
            dir_up_q     <= 1'b1;
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= ctrl_q.start;
            if (clr_wr) begin
                cnt_q    <= `EBT_CNT_ZERO;
                dir_up_q <= 1'b1;
            end else if (ctrl_q.mode == ebt_pkg::EBT_DOWN
                         && ctrl_q.start && !start_prev_q) begin
                cnt_q <= cval_q;
            end else if (upd) begin
                cnt_q    <= cnt_d;
                dir_up_q <= dir_up_d;
            end
        end
    end

    // compare events on each counter step
    assign act_en   = upd & ~clr_wr & cctl_q.compare_en;
    assign match_ev = act_en & (cnt_d == cval_q);
    assign zero_ev  = act_en & (cnt_d == `EBT_CNT_ZERO);
    assign max_ev   = act_en & (cnt_d == `EBT_CNT_MAX);

    always_comb begin
        out_d = out_q;
        case (cctl_q.compare_output_action)
            ebt_pkg::EBT_SET: if (match_ev) out_d = 1'b1;
            ebt_pkg::EBT_CLEAR: if (match_ev) out_d = 1'b0;
            ebt_pkg::EBT_TOGGLE: if (match_ev) out_d = ~out_q;
            ebt_pkg::EBT_SET_UP: begin
                if (match_ev && step_up) begin
                    out_d = 1'b1;
                end else if (ctrl_q.mode == ebt_pkg::EBT_UPDOWN) begin
                    if (match_ev) out_d = 1'b0;
                end else if (zero_ev) begin
                    out_d = 1'b0;
                end
            end
            ebt_pkg::EBT_CLR_UP: begin
                if (match_ev && step_up) begin
                    out_d = 1'b0;
                end else if (ctrl_q.mode == ebt_pkg::EBT_UPDOWN) begin
                    if (match_ev) out_d = 1'b1;
                end else if (zero_ev) begin
                    out_d = 1'b1;
                end
            end
            ebt_pkg::EBT_SET_CLRFF: begin
                if (match_ev) out_d = 1'b1;
                else if (max_ev) out_d = 1'b0;
            end
            ebt_pkg::EBT_CLR_SET0: begin
                if (match_ev) out_d = 1'b0;
                else if (zero_ev) out_d = 1'b1;
            end
            default: out_d = out_q;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_q  <= 1'b0;
            cirq_q <= 1'b0;
            oirq_q <= 1'b0;
        end else begin
            out_q  <= out_d;
            cirq_q <= match_ev & cctl_q.channel_irq_mask;
            oirq_q <= upd & ~clr_wr & ovf_ev & ctrl_q.overflow_irq_mask;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    clear_zero_a: assert property (clr_wr |=> cnt_q == `EBT_CNT_ZERO)
        else $error("counter not zero after clear");
    clear_reads_a: assert property (pready_q |-> !prdata_q[`EBT_CTL_CLR]
        || $past(idx) != `EBT_IDX_CTRL)
        else $error("clear bit read back as one");
    hold_stop_a: assert property (!ctrl_q.start && !clr_wr |=> $stable(cnt_q))
        else $error("counter moved while suspended");
    rate_div_a: assert property (upd |-> tick
        && (presc_q & presc_mask) == presc_mask)
        else $error("update off prescaled edge");
    free_wrap_a: assert property (upd && !clr_wr && ctrl_q.mode == ebt_pkg::EBT_FREE
        && cnt_q == `EBT_CNT_MAX |=> cnt_q == `EBT_CNT_ZERO ##0 oirq_q
        == ctrl_q.overflow_irq_mask)
        else $error("free mode wrap wrong");
    mod_wrap_a: assert property (upd && !clr_wr && ctrl_q.mode == ebt_pkg::EBT_MODULO
        && cnt_q == cval_q |=> cnt_q == `EBT_CNT_ZERO)
        else $error("modulo wrap wrong");
    down_step_a: assert property (upd && !clr_wr && ctrl_q.mode == ebt_pkg::EBT_DOWN
        && start_prev_q && cnt_q != `EBT_CNT_ZERO
        |=> cnt_q == $past(cnt_q) - `EBT_CNT_ONE)
        else $error("down step wrong");
    count_read_a: assert property (pready_q && $past(idx) == `EBT_IDX_COUNT
        |-> prdata_q[7:0] == $past(cnt_q))
        else $error("count read mismatch");
    set_match_a: assert property (match_ev && cctl_q.compare_output_action
        == ebt_pkg::EBT_SET |=> out_q)
        else $error("set on compare missed");
    cmp_off_a: assert property (!cctl_q.compare_en |=> $stable(out_q) && !cirq_q)
        else $error("compare acted while disabled");
    irq_mask_a: assert property (cirq_q |-> $past(match_ev)
        && $past(cctl_q.channel_irq_mask))
        else $error("channel irq without masked match");

    free_cover_c: cover property (upd && ctrl_q.mode == ebt_pkg::EBT_FREE
        && cnt_q == `EBT_CNT_MAX);
    updown_cover_c: cover property (upd && ctrl_q.mode == ebt_pkg::EBT_UPDOWN
        && !dir_up_d && dir_up_q);
    match_cover_c: cover property (cirq_q);
    clear_cover_c: cover property (clr_wr && cnt_q != `EBT_CNT_ZERO);

endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the eight-bit compare timer
`timescale 1ns/1ps
`default_nettype none
`include "ebt_map.svh"
module tb_top;
    logic        clk;
    logic        reset_n;
    logic        tick;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        chan0_out;
    logic        chan0_irq;
    logic        overflow_irq;
    logic [31:0] rdat;
    logic        rerr;
    int          err_total;
    int          cmp_count;
    int          ovf_n;
    int          chn_n;
    int          snap;
    // action sequence chosen so that every step changes the output
    logic [2:0]  act_t [10] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h0, 3'h6, 3'h4, 3'h1, 3'h5};
    logic        m_t   [10] = '{1, 0, 1, 0, 1, 1, 0, 0, 0, 1};
    int          far_t [10] = '{0, 0, 0, 0, 254, 0, 254, 254, 0, 253};
    logic        f_t   [10] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0};

    ebt_timer #(.PRESC_W(7)) ebt_timer_i (
        .clk          (clk),
        .reset_n      (reset_n),
        .tick         (tick),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .chan0_out    (chan0_out),
        .chan0_irq    (chan0_irq),
        .overflow_irq (overflow_irq)
    );

    initial clk = 1'b0;
    always #2 clk = ~clk;

    // irq lines are one-cycle pulses, counted at the clock
    always @(posedge clk) begin
        if (overflow_irq === 1'b1) ovf_n++;
        if (chan0_irq === 1'b1) chn_n++;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // pready sampled at the rising edge; release only after that edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_total++;
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string name);
        apb(1'b0, idx, 8'h00);
        chk(name, exp, rdat);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        cmp_count = 0;
        ovf_n     = 0;
        chn_n     = 0;
        reset_n   = 1'b0;
        tick      = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "count reset");
        rd(`EBT_IDX_CTRL, 32'h0000_0008, "control reset");
        rd(`EBT_IDX_CCTL, 32'h0000_0040, "channel control reset");
        rd(`EBT_IDX_CVAL, 32'h0000_0000, "compare reset");
        apb(1'b0, 10'h0ee, 8'h00);
        chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
        wr(`EBT_IDX_COUNT, 8'h55);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "count read-only");
        pulse(5);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "count held");
        wr(`EBT_IDX_CTRL, 8'h18);
        pulse(5);
        rd(`EBT_IDX_COUNT, 32'h0000_0005, "count running");
        wr(`EBT_IDX_CTRL, 8'h1c);
        rd(`EBT_IDX_CTRL, 32'h0000_0018, "clear reads zero");
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "count cleared");
        pulse(3);
        wr(`EBT_IDX_CTRL, 8'h18);
        rd(`EBT_IDX_COUNT, 32'h0000_0003, "clear zero ignored");
        for (int d = 0; d < 8; d++) begin
            wr(`EBT_IDX_CTRL, {d[2:0], 5'h1c});
            pulse(2 << d);
            rd(`EBT_IDX_COUNT, 32'h0000_0002, "prescaled count");
        end
        wr(`EBT_IDX_CTRL, 8'h18);
        pulse(3);
        rd(`EBT_IDX_COUNT, 32'h0000_0005, "divider change at once");
        wr(`EBT_IDX_CTRL, 8'h1c);
        pulse(255);
        rd(`EBT_IDX_COUNT, 32'h0000_00ff, "free top");
        snap = ovf_n;
        pulse(1);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "free wrap");
        chk("overflow pulse", snap + 1, ovf_n);
        wr(`EBT_IDX_CTRL, 8'h14);
        pulse(256);
        chk("overflow masked", snap + 1, ovf_n);
        wr(`EBT_IDX_CVAL, 8'h03);
        rd(`EBT_IDX_CVAL, 32'h0000_0003, "compare readback");
        wr(`EBT_IDX_CTRL, 8'h1e);
        snap = ovf_n;
        pulse(4);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "modulo restart");
        chk("modulo overflow", snap + 1, ovf_n);
        pulse(3);
        rd(`EBT_IDX_COUNT, 32'h0000_0003, "modulo limit");
        wr(`EBT_IDX_CTRL, 8'h1f);
        pulse(3);
        rd(`EBT_IDX_COUNT, 32'h0000_0003, "updown top");
        pulse(2);
        rd(`EBT_IDX_COUNT, 32'h0000_0001, "updown falling");
        pulse(1);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "updown bottom");
        wr(`EBT_IDX_CVAL, 8'h05);
        wr(`EBT_IDX_CTRL, 8'h0d);
        wr(`EBT_IDX_CTRL, 8'h19);
        rd(`EBT_IDX_COUNT, 32'h0000_0005, "down load");
        pulse(2);
        rd(`EBT_IDX_COUNT, 32'h0000_0003, "down step");
        pulse(5);
        rd(`EBT_IDX_COUNT, 32'h0000_0000, "down end");
        wr(`EBT_IDX_CVAL, 8'h02);
        snap = chn_n;
        for (int i = 0; i < 10; i++) begin
            wr(`EBT_IDX_CCTL, {2'b01, act_t[i], 3'b100});
            wr(`EBT_IDX_CTRL, 8'h1c);
            pulse(2);
            chk("output on match", {31'h0000_0000, m_t[i]}, {31'h0000_0000, chan0_out});
            if (far_t[i] != 0) begin
                pulse(far_t[i]);
                chk("output at end", {31'h0000_0000, f_t[i]}, {31'h0000_0000, chan0_out});
            end
        end
        chk("channel irq count", snap + 10, chn_n);
        wr(`EBT_IDX_CCTL, 8'h40);
        wr(`EBT_IDX_CTRL, 8'h1c);
        pulse(2);
        chk("compare disabled", 32'h0000_0000, {31'h0000_0000, chan0_out});
        chk("disabled irq", snap + 10, chn_n);
        wr(`EBT_IDX_CCTL, 8'h04);
        wr(`EBT_IDX_CTRL, 8'h1c);
        pulse(2);
        chk("masked match output", 32'h0000_0001, {31'h0000_0000, chan0_out});
        chk("channel irq masked", snap + 10, chn_n);
        wr(`EBT_IDX_CCTL, 8'h3c);
        wr(`EBT_IDX_CTRL, 8'h1c);
        pulse(2);
        chk("unused action", 32'h0000_0001, {31'h0000_0000, chan0_out});
        rd(`EBT_IDX_CCTL, 32'h0000_003c, "channel control readback");
        complete_run();
    end
endmodule
`default_nettype wire
